// [hdl/isc_pkg.sv]
/*
  Constants, register map and state codes of the I2C slave status/control block.
  Assumes a 32-bit APB master and an open-drain I2C bus resolved outside the design.
*/
// Notes on behaviour
// R1 - Done flag low while a byte moves, high with interrupt after 8 bits.
// R2 - Address-match flag high on own address, low when addresses differ.
// R3 - Busy flag set on START, cleared on STOP.
// R4 - Software sets direction select 1 to transmit, 0 to receive.
// R5 - After eight received bits, tx ack level drives SDA on 9th clock.
// R6 - Software clears tx ack level before further bytes are received.
// R7 - Eighth bit after START is captured into the master-read flag.
// R8 - Software picks transmit when master-read is 1, receive when 0.
// R9 - With match wake enable set, an address match wakes the part.
// R10 - Software clears match wake enable after waking.
// R11 - Transmitter records master ack on 9th clock: 0 ack, 1 no ack.
// R12 - Transmitter continues while acked, releases SDA once no ack seen.
// R13 - First seven bits after START, MSB first, compared with own address.
// R14 - On match the slave pulls SDA low as the 9th address bit.
// R15 - START is SDA falling while SCL stays high.
// R16 - After match, SCL held until data write (transmit) or dummy read (receive).
// R17 - Interrupt causes: match, byte done, time-out; software tells them apart. The core has no time-out cause, only match and byte done.
// R18 - Software sets mode 110 and enable, own address, then interrupts.
// R19 - The slave never generates a START condition.
// R20 - Enable rising in I2C mode resets flags, keeps direction and tx ack.
// R21 - Data bytes are eight bits, MSB first, after address acknowledge.
// R22 - Writes to read-only status flags are ignored.
// R23 - Status/control register resets to 0x81.
package isc_pkg;
  localparam int unsigned ADDR_W        = 8;
  localparam int unsigned REG_IDX_W     = 2;
  localparam logic [1:0]  IDX_MODE_CTRL = 2'h0;
  localparam logic [1:0]  IDX_STATUS    = 2'h1;
  localparam logic [1:0]  IDX_DATA      = 2'h2;
  localparam logic [1:0]  IDX_OWN_ADDR  = 2'h3;
  localparam logic [7:0]  OFF_MODE_CTRL = 8'h00;
  localparam logic [7:0]  OFF_STATUS    = 8'h04;
  localparam logic [7:0]  OFF_DATA      = 8'h08;
  localparam logic [7:0]  OFF_OWN_ADDR  = 8'h0c;

  localparam int unsigned ST_DONE  = 7;
  localparam int unsigned ST_MATCH = 6;
  localparam int unsigned ST_BUSY  = 5;
  localparam int unsigned ST_DIR   = 4;
  localparam int unsigned ST_TXACK = 3;
  localparam int unsigned ST_MREAD = 2;
  localparam int unsigned ST_WAKE  = 1;
  localparam int unsigned ST_NACK  = 0;
  localparam logic [7:0]  STATUS_RESET   = 8'h81;
  localparam logic [7:0]  STATUS_WR_MASK = 8'h1a;

  localparam int unsigned MODE_LSB        = 5;
  localparam int unsigned ENABLE_BIT      = 1;
  localparam logic [2:0]  MODE_I2C_SLAVE  = 3'h6;
  localparam logic [7:0]  MODE_CTRL_RESET = 8'he0;
  localparam logic [7:0]  MODE_CTRL_MASK  = 8'hee;
  localparam logic [7:0]  OWN_ADDR_RESET  = 8'h00;
  localparam logic [7:0]  DATA_RESET      = 8'h00;
  localparam logic [3:0]  BYTE_BITS       = 4'h8;

  typedef enum logic [7:0] {
    ISC_IDLE     = 8'b00000001,
    ISC_ADDR     = 8'b00000010,
    ISC_ADDR_ACK = 8'b00000100,
    ISC_HOLD     = 8'b00001000,
    ISC_RX       = 8'b00010000,
    ISC_RX_ACK   = 8'b00100000,
    ISC_TX       = 8'b01000000,
    ISC_TX_ACK   = 8'b10000000
  } isc_state_e;
endpackage

// [hdl/isc_reg_if.sv]
/*
  Register access carrier between the APB slave and the core.
  Assumes one strobe per completed APB transfer.
*/
`timescale 1ns/10ps
interface isc_reg_if;
  logic       wrStb;
  logic       rdStb;
  logic [1:0] regIdx;
  logic [7:0] wrData;
  logic [7:0] rdData;

  modport bus (output wrStb, output rdStb, output regIdx, output wrData, input rdData);
  modport core (input wrStb, input rdStb, input regIdx, input wrData, output rdData);
endinterface

// [hdl/isc_pin_sync.sv]
/*
  Three-stage synchroniser with agreement filter for bus pins.
  Assumes asynchronous inputs; output moves once stages two and three agree.
*/
`timescale 1ns/10ps
module isc_pin_sync #(
  parameter int unsigned WIDTH = 2
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // Pins
  input  wire logic [WIDTH-1:0] pinRaw,
  output logic      [WIDTH-1:0] pinLvl
);
  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stage1_reg <= '1;
      stage2_reg <= '1;
      stage3_reg <= '1;
    end else begin
      stage1_reg <= pinRaw;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        pinLvl[i] <= 1'b1;
      end else if (stage2_reg[i] == stage3_reg[i]) begin
        pinLvl[i] <= stage3_reg[i];
      end
    end
  end
endmodule // isc_pin_sync

// [hdl/isc_apb_slave.sv]
/*
  APB slave front end: one wait state, registered read data, error on unmapped words.
  Assumes a compliant APB master holding the request until pready.
*/
`timescale 1ns/10ps
module isc_apb_slave (
  // Clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      rst,
  // APB
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [isc_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  // Core side
  isc_reg_if.bus                         regs
);
  logic accessPh;
  logic mapped;
  logic done;

  assign accessPh = psel & penable;
  assign mapped   = (paddr[1:0] == 2'h0) && (paddr[isc_pkg::ADDR_W-1:4] == '0);
  assign done     = accessPh & pready;
  assign pslverr  = done & ~mapped;

  assign regs.regIdx = paddr[3:2];
  assign regs.wrData = pwdata[7:0];
  assign regs.wrStb  = done & pwrite & mapped;
  assign regs.rdStb  = done & ~pwrite & mapped;

  // Wait state and read capture
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= accessPh & ~pready;
      if (accessPh && !pready) begin
        prdata <= (mapped && !pwrite) ? {24'h0, regs.rdData} : 32'h0;
      end
    end
  end
endmodule // isc_apb_slave

// [hdl/isc_top.sv]
/*
  Slave-only I2C engine with status/control, data, own-address and mode registers.
  Assumes an external I2C master driving SCL and open-drain resolution outside.
*/
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/10ps
module isc_top (
  // Clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       rst,
  // APB
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [isc_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // I2C pins
  input  wire logic                       sclIn,
  output logic                            sclOut,
  output logic                            sclOe,
  input  wire logic                       sdaIn,
  output logic                            sdaOut,
  output logic                            sdaOe,
  // Events
  output logic                            serialIrq,
  output logic                            wakeReq
);
  isc_reg_if regs ();

  isc_apb_slave u_apb (
    .clk_sys (clk_sys),
    .rst     (rst),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .regs    (regs)
  );

  logic [1:0] pinLvl;
  logic       sclLvl;
  logic       sdaLvl;

  isc_pin_sync #(.WIDTH(2)) u_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pinRaw  ({sclIn, sdaIn}),
    .pinLvl  (pinLvl)
  );
  assign sclLvl = pinLvl[1];
  assign sdaLvl = pinLvl[0];

  isc_pkg::isc_state_e state_reg;
  logic [7:0]          modeCtrl_reg;
  logic [7:0]          status_reg;
  logic [7:0]          data_reg;
  logic [7:0]          ownAddr_reg;
  logic [7:0]          shift_reg;
  logic [3:0]          bitCnt_reg;
  logic                sdaDrive_reg;
  logic                sclPrev_reg;
  logic                sdaPrev_reg;
  logic                enPrev_reg;
  logic                irq_reg;
  logic                wake_reg;

  logic       enabled;
  logic       enRise;
  logic       sclRise;
  logic       sclFall;
  logic       startDet;
  logic       stopDet;
  logic [7:0] shiftNext;
  logic       addrByteEv;
  logic       addrHit;
  logic       rxByteEv;
  logic       txAckEv;
  logic       doneEv;
  logic       dataWr;
  logic       dataRd;
  logic       holdRelease;

  // Bus event decode
  assign enabled    = (modeCtrl_reg[7:isc_pkg::MODE_LSB] == isc_pkg::MODE_I2C_SLAVE)
                      && modeCtrl_reg[isc_pkg::ENABLE_BIT];
  assign enRise     = enabled & ~enPrev_reg;
  assign sclRise    = sclLvl & ~sclPrev_reg;
  assign sclFall    = ~sclLvl & sclPrev_reg;
  assign startDet   = enabled & sclLvl & sclPrev_reg & sdaPrev_reg & ~sdaLvl; // [R15]
  assign stopDet    = enabled & sclLvl & sclPrev_reg & ~sdaPrev_reg & sdaLvl;
  assign shiftNext  = {shift_reg[6:0], sdaLvl}; // [R21]
  assign addrByteEv = (state_reg == isc_pkg::ISC_ADDR) && sclRise && (bitCnt_reg == 4'h7);
  assign addrHit    = addrByteEv && (shiftNext[7:1] == ownAddr_reg[7:1]); // [R13]
  assign rxByteEv   = (state_reg == isc_pkg::ISC_RX) && sclRise && (bitCnt_reg == 4'h7);
  assign txAckEv    = (state_reg == isc_pkg::ISC_TX_ACK) && sclRise;
  assign doneEv     = addrHit | rxByteEv | txAckEv;
  assign dataWr     = regs.wrStb && (regs.regIdx == isc_pkg::IDX_DATA);
  assign dataRd     = regs.rdStb && (regs.regIdx == isc_pkg::IDX_DATA);
  assign holdRelease = (state_reg == isc_pkg::ISC_HOLD)
                       && ((dataWr && status_reg[isc_pkg::ST_DIR])
                           || (dataRd && !status_reg[isc_pkg::ST_DIR])); // [R16]

  // Open-drain drivers only ever pull low
  assign sclOut    = 1'b0;
  assign sdaOut    = 1'b0;
  assign sclOe     = (state_reg == isc_pkg::ISC_HOLD); // [R16]
  assign sdaOe     = sdaDrive_reg;
  assign serialIrq = irq_reg;
  assign wakeReq   = wake_reg;

  // Read mux
  always_comb begin
    unique case (regs.regIdx)
      isc_pkg::IDX_MODE_CTRL: regs.rdData = modeCtrl_reg;
      isc_pkg::IDX_STATUS:    regs.rdData = status_reg;
      isc_pkg::IDX_DATA:      regs.rdData = data_reg;
      isc_pkg::IDX_OWN_ADDR:  regs.rdData = ownAddr_reg;
    endcase
  end

  // Line history
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sclPrev_reg <= 1'b1;
      sdaPrev_reg <= 1'b1;
      enPrev_reg  <= 1'b0;
    end else begin
      sclPrev_reg <= sclLvl;
      sdaPrev_reg <= sdaLvl;
      enPrev_reg  <= enabled;
    end
  end

  // Configuration registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      modeCtrl_reg <= isc_pkg::MODE_CTRL_RESET;
      ownAddr_reg  <= isc_pkg::OWN_ADDR_RESET;
    end else if (regs.wrStb) begin
      if (regs.regIdx == isc_pkg::IDX_MODE_CTRL) begin
        modeCtrl_reg <= regs.wrData & isc_pkg::MODE_CTRL_MASK;
      end
      if (regs.regIdx == isc_pkg::IDX_OWN_ADDR) begin
        ownAddr_reg <= regs.wrData;
      end
    end
  end

  // Data register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      data_reg <= isc_pkg::DATA_RESET;
    end else if (rxByteEv) begin
      data_reg <= shiftNext; // [R21]
    end else if (dataWr) begin
      data_reg <= regs.wrData;
    end
  end

  // Status/control flags
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      status_reg <= isc_pkg::STATUS_RESET; // [R23]
    end else if (enRise) begin
      status_reg[isc_pkg::ST_DONE]  <= isc_pkg::STATUS_RESET[isc_pkg::ST_DONE]; // [R20]
      status_reg[isc_pkg::ST_MATCH] <= isc_pkg::STATUS_RESET[isc_pkg::ST_MATCH];
      status_reg[isc_pkg::ST_BUSY]  <= isc_pkg::STATUS_RESET[isc_pkg::ST_BUSY];
      status_reg[isc_pkg::ST_MREAD] <= isc_pkg::STATUS_RESET[isc_pkg::ST_MREAD];
      status_reg[isc_pkg::ST_NACK]  <= isc_pkg::STATUS_RESET[isc_pkg::ST_NACK];
    end else begin
      if (regs.wrStb && (regs.regIdx == isc_pkg::IDX_STATUS)) begin
        status_reg[isc_pkg::ST_DIR]   <= regs.wrData[isc_pkg::ST_DIR]; // [R22]
        status_reg[isc_pkg::ST_TXACK] <= regs.wrData[isc_pkg::ST_TXACK];
        status_reg[isc_pkg::ST_WAKE]  <= regs.wrData[isc_pkg::ST_WAKE];
      end
      if (startDet) begin
        status_reg[isc_pkg::ST_BUSY] <= 1'b1; // [R3]
      end else if (stopDet) begin
        status_reg[isc_pkg::ST_BUSY] <= 1'b0; // [R3]
      end
      if (doneEv) begin
        status_reg[isc_pkg::ST_DONE] <= 1'b1; // [R1]
      end else if (startDet || holdRelease) begin
        status_reg[isc_pkg::ST_DONE] <= 1'b0; // [R1]
      end
      if (addrByteEv) begin
        status_reg[isc_pkg::ST_MATCH] <= addrHit; // [R2]
        status_reg[isc_pkg::ST_MREAD] <= sdaLvl; // [R7]
      end else if (startDet || holdRelease) begin
        status_reg[isc_pkg::ST_MATCH] <= 1'b0;
      end
      if (txAckEv) begin
        status_reg[isc_pkg::ST_NACK] <= sdaLvl; // [R11]
      end
    end
  end

  // Interrupt and wake pulses
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_reg  <= 1'b0;
      wake_reg <= 1'b0;
    end else begin
      irq_reg  <= doneEv & enabled; // [R1] [R13]
      wake_reg <= addrHit & status_reg[isc_pkg::ST_WAKE]; // [R9]
    end
  end

  // Transfer sequencer
  always_ff @(posedge clk_sys) begin
    if (rst || !enabled) begin
      state_reg    <= isc_pkg::ISC_IDLE;
      bitCnt_reg   <= 4'h0;
      shift_reg    <= 8'h0;
      sdaDrive_reg <= 1'b0;
    end else if (startDet) begin
      state_reg    <= isc_pkg::ISC_ADDR;
      bitCnt_reg   <= 4'h0;
      sdaDrive_reg <= 1'b0;
    end else if (stopDet) begin
      state_reg    <= isc_pkg::ISC_IDLE;
      sdaDrive_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        isc_pkg::ISC_IDLE: begin
          sdaDrive_reg <= 1'b0;
        end
        isc_pkg::ISC_ADDR, isc_pkg::ISC_RX: begin
          if (sclRise) begin
            shift_reg  <= shiftNext; // [R13] [R21]
            bitCnt_reg <= bitCnt_reg + 4'h1;
          end else if (sclFall && bitCnt_reg == isc_pkg::BYTE_BITS) begin
            bitCnt_reg <= 4'h0;
            if (state_reg == isc_pkg::ISC_RX) begin
              sdaDrive_reg <= ~status_reg[isc_pkg::ST_TXACK]; // [R5]
              state_reg    <= isc_pkg::ISC_RX_ACK;
            end else if (status_reg[isc_pkg::ST_MATCH]) begin
              sdaDrive_reg <= 1'b1; // [R14]
              state_reg    <= isc_pkg::ISC_ADDR_ACK;
            end else begin
              state_reg <= isc_pkg::ISC_IDLE;
            end
          end
        end
        isc_pkg::ISC_ADDR_ACK, isc_pkg::ISC_RX_ACK: begin
          if (sclFall) begin
            sdaDrive_reg <= 1'b0;
            state_reg    <= isc_pkg::ISC_HOLD; // [R16]
          end
        end
        isc_pkg::ISC_HOLD: begin
          if (holdRelease && status_reg[isc_pkg::ST_DIR]) begin
            shift_reg    <= regs.wrData;
            sdaDrive_reg <= ~regs.wrData[7]; // [R21]
            bitCnt_reg   <= 4'h0;
            state_reg    <= isc_pkg::ISC_TX;
          end else if (holdRelease) begin
            bitCnt_reg <= 4'h0;
            state_reg  <= isc_pkg::ISC_RX;
          end
        end
        isc_pkg::ISC_TX: begin
          if (sclRise) begin
            bitCnt_reg <= bitCnt_reg + 4'h1;
          end else if (sclFall && bitCnt_reg == isc_pkg::BYTE_BITS) begin
            sdaDrive_reg <= 1'b0;
            bitCnt_reg   <= 4'h0;
            state_reg    <= isc_pkg::ISC_TX_ACK;
          end else if (sclFall) begin
            sdaDrive_reg <= ~shift_reg[6];
            shift_reg    <= {shift_reg[6:0], 1'b0};
          end
        end
        isc_pkg::ISC_TX_ACK: begin
          if (sclFall) begin
            sdaDrive_reg <= 1'b0;
            state_reg    <= status_reg[isc_pkg::ST_NACK] ? isc_pkg::ISC_IDLE : isc_pkg::ISC_HOLD; // [R12]
          end
        end
      endcase
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  status_reset_a: assert property ($past(rst) |-> status_reg == isc_pkg::STATUS_RESET) // [R23]
    else $error("status register not at reset value");
  busy_start_a: assert property (startDet |=> status_reg[isc_pkg::ST_BUSY]) // [R3]
    else $error("busy flag not set after start");
  busy_stop_a: assert property (stopDet && !startDet |=> !status_reg[isc_pkg::ST_BUSY]) // [R3]
    else $error("busy flag not cleared after stop");
  no_start_a: assert property ($rose(sdaOe) |-> !sclLvl) // [R19]
    else $error("slave pulled SDA while SCL high");
  addr_ack_a: assert property (addrHit && enabled ##1 (state_reg != isc_pkg::ISC_IDLE)[*1] |-> // [R14]
                               ##[1:400] (state_reg == isc_pkg::ISC_ADDR_ACK && sdaOe) or stopDet or startDet)
    else $error("matched address not acknowledged");
  done_irq_a: assert property (doneEv && enabled |=> serialIrq && status_reg[isc_pkg::ST_DONE]) // [R1]
    else $error("byte completion without flag and interrupt");
  match_flag_a: assert property (addrByteEv && enabled && !enRise |=> // [R2]
                                 status_reg[isc_pkg::ST_MATCH] == ($past(shiftNext[7:1]) == ownAddr_reg[7:1]))
    else $error("address match flag wrong");
  mread_cap_a: assert property (addrByteEv && enabled && !enRise |=> status_reg[isc_pkg::ST_MREAD] == $past(sdaLvl)) // [R7]
    else $error("master read flag not captured");
  rx_nack_a: assert property (txAckEv && enabled && !enRise |=> status_reg[isc_pkg::ST_NACK] == $past(sdaLvl)) // [R11]
    else $error("receive acknowledge flag wrong");
  hold_release_a: assert property (state_reg == isc_pkg::ISC_HOLD && !holdRelease && !startDet && !stopDet // [R16]
                                   && !(regs.wrStb && regs.regIdx == isc_pkg::IDX_MODE_CTRL)
                                   |=> sclOe)
    else $error("SCL released without service");
  tx_ack_drive_a: assert property (state_reg == isc_pkg::ISC_RX_ACK |-> // [R5]
                                   sdaOe == !status_reg[isc_pkg::ST_TXACK]
                                   || $changed(status_reg[isc_pkg::ST_TXACK]))
    else $error("tx ack level not on SDA");
  enable_rise_a: assert property (enRise |=> status_reg[isc_pkg::ST_DONE] && status_reg[isc_pkg::ST_NACK] // [R20]
                                  && !status_reg[isc_pkg::ST_BUSY]
                                  && status_reg[isc_pkg::ST_DIR] == $past(status_reg[isc_pkg::ST_DIR]))
    else $error("flags not defaulted on enable");
  ro_write_a: assert property (regs.wrStb && regs.regIdx == isc_pkg::IDX_STATUS && !doneEv && !startDet // [R22]
                               && !stopDet && !addrByteEv && !txAckEv && !holdRelease && !enRise
                               |=> status_reg[7:5] == $past(status_reg[7:5]))
    else $error("read-only flag changed by write");
  wake_match_a: assert property (wakeReq == ($past(addrHit) && $past(status_reg[isc_pkg::ST_WAKE]))) // [R9]
    else $error("wake request does not follow enabled match");
  nack_release_a: assert property (state_reg == isc_pkg::ISC_TX_ACK && status_reg[isc_pkg::ST_NACK] // [R12]
                                   && sclFall && !startDet && !stopDet |=> !sdaOe && state_reg == isc_pkg::ISC_IDLE)
    else $error("SDA not released after no acknowledge");
  rx_data_a: assert property (rxByteEv |=> data_reg == $past(shiftNext)) // [R21]
    else $error("received byte not stored");
  tx_first_bit_a: assert property (holdRelease && status_reg[isc_pkg::ST_DIR] && enabled // [R21]
                                   && !startDet && !stopDet |=> sdaOe == !$past(regs.wrData[7]))
    else $error("first transmit bit not on SDA");

  match_c: cover property (addrHit ##[1:400] state_reg == isc_pkg::ISC_HOLD);
  rx_byte_c: cover property (rxByteEv ##[1:400] state_reg == isc_pkg::ISC_RX_ACK);
  tx_nack_c: cover property (txAckEv && sdaLvl);
  wake_c: cover property (wakeReq);
  tx_hold_c: cover property (txAckEv && !sdaLvl ##[1:400] state_reg == isc_pkg::ISC_HOLD);
endmodule // isc_top

// [verification/isc_i2c_master.sv]
/*
  I2C bus master model: START, STOP and nine-bit transfers.
  Assumes wired-AND bus levels with pull-ups, resolved by the bench.
*/
`timescale 1ns/10ps
module isc_i2c_master (
  // Bus levels
  input  wire logic sclBus,
  input  wire logic sdaBus,
  // Pull-down requests
  output logic      sclLow,
  output logic      sdaLow
);
  localparam realtime Q = 31.25;

  initial begin
    sclLow = 1'b0;
    sdaLow = 1'b0;
  end

  // One bit; waits while the slave stretches SCL
  task automatic bitIo(input logic b, output logic s);
    int n;
    sdaLow = !b;
    #Q sclLow = 1'b0;
    for (n = 0; n < 5000 && sclBus !== 1'b1; n++) #10;
    #Q s = sdaBus;
    #Q sclLow = 1'b1;
    #Q;
  endtask

  // Eight bits MSB first, then the ninth clock
  task automatic xfer(input logic [8:0] o, output logic [8:0] i);
    for (int k = 8; k >= 0; k--) bitIo(o[k], i[k]);
    #100;
  endtask

  // SDA falls while SCL stays high
  task automatic start();
    sdaLow = 1'b1;
    #(2*Q) sclLow = 1'b1;
    #Q;
  endtask

  task automatic stop();
    sdaLow = 1'b1;
    #Q sclLow = 1'b0;
    #(2*Q) sdaLow = 1'b0;
    #(2*Q);
  endtask
endmodule // isc_i2c_master

// [verification/i2c_slave_status_control_bench.sv]
/*
  Bench for the I2C slave block: APB register tests and bus transfers.
  Assumes the master model and a wired-AND bus with pull-ups.
*/
`timescale 1ns/10ps
module i2c_slave_status_control_bench;
  localparam logic [7:0] MC = isc_pkg::OFF_MODE_CTRL;
  localparam logic [7:0] ST = isc_pkg::OFF_STATUS;
  localparam logic [7:0] DT = isc_pkg::OFF_DATA;
  localparam logic [7:0] OA = isc_pkg::OFF_OWN_ADDR;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, sclOut, sclOe, sdaOut, sdaOe, serialIrq, wakeReq;
  logic        mScl, mSda, lastErr;
  logic [8:0]  ri;
  logic [7:0]  rxB [2] = '{8'ha5, 8'h3c};
  logic [7:0]  txB [2] = '{8'hc3, 8'h96};
  int          n_mismatch = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          irqCnt = 0;
  int          wakeCnt = 0;
  wire logic   sclBus = ~(mScl | (sclOe & ~sclOut));
  wire logic   sdaBus = ~(mSda | (sdaOe & ~sdaOut));

  isc_top u_dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclIn(sclBus), .sclOut(sclOut),
    .sclOe(sclOe), .sdaIn(sdaBus), .sdaOut(sdaOut), .sdaOe(sdaOe), .serialIrq(serialIrq), .wakeReq(wakeReq));
  isc_i2c_master u_mst (.sclBus(sclBus), .sdaBus(sdaBus), .sclLow(mScl), .sdaLow(mSda));

  always #5 clk_sys = ~clk_sys;

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    lastErr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdChk(input string nm, input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(nm, rd & {24'h0, m}, {24'h0, e});
  endtask

  // Pulse counters and timeout
  always @(posedge clk_sys) begin
    cyc++;
    if (serialIrq === 1'b1) irqCnt++;
    if (wakeReq === 1'b1) wakeCnt++;
    if (cyc == 20000) begin
      n_mismatch++;
      close_out();
    end
  end

  // Only the master may make SDA fall under a high SCL
  always @(negedge sdaBus) begin
    if (sclBus === 1'b1) chk("start_src", mSda, 1);
  end

  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    rdChk("status_rst", ST, 8'hff, 8'h81);
    rdChk("mode_rst", MC, 8'hff, 8'he0);
    apb(1'b1, ST, 8'hff);
    rdChk("status_wr", ST, 8'hff, 8'h9b);
    apb(1'b1, ST, 8'h18);
    apb(1'b0, 8'h10, 8'h00);
    chk("slverr", lastErr, 1);
    apb(1'b1, MC, 8'hc2);
    apb(1'b1, OA, 8'h54);
    rdChk("status_en", ST, 8'hff, 8'h99);
    apb(1'b1, ST, 8'h00);
    u_mst.start();
    rdChk("busy", ST, 8'ha0, 8'h20);
    u_mst.xfer({8'h54, 1'b1}, ri);
    chk("addr_ack", ri[0], 0);
    rdChk("match", ST, 8'he4, 8'he0);
    chk("hold", sclOe, 1);
    chk("irq_addr", irqCnt, 1);
    apb(1'b0, DT, 8'h00);
    repeat (2) @(posedge clk_sys);
    chk("release", sclOe, 0);
    foreach (rxB[k]) begin
      apb(1'b1, ST, {4'h0, k[0], 3'h0});
      u_mst.xfer({rxB[k], 1'b1}, ri);
      chk("rx_ack", ri[0], k[0]);
      rdChk("rx_data", DT, 8'hff, rxB[k]);
      chk("irq_byte", irqCnt, k + 2);
    end
    u_mst.stop();
    rdChk("free", ST, 8'h20, 8'h00);
    apb(1'b1, ST, 8'h02);
    u_mst.start();
    u_mst.xfer({8'h56, 1'b1}, ri);
    chk("no_ack", ri[0], 1);
    rdChk("no_match", ST, 8'h40, 8'h00);
    chk("no_wake", wakeCnt, 0);
    u_mst.stop();
    u_mst.start();
    u_mst.xfer({8'h55, 1'b1}, ri);
    rdChk("mread", ST, 8'h44, 8'h44);
    chk("wake", wakeCnt, 1);
    apb(1'b1, ST, 8'h10);
    foreach (txB[k]) begin
      apb(1'b1, DT, txB[k]);
      u_mst.xfer({8'hff, k[0]}, ri);
      chk("tx_data", ri[8:1], txB[k]);
      rdChk("rx_nack", ST, 8'h01, {7'h0, k[0]});
    end
    chk("sda_free", sdaOe, 0);
    chk("scl_free", sclOe, 0);
    u_mst.stop();
    apb(1'b1, MC, 8'h00);
    apb(1'b1, MC, 8'hc2);
    rdChk("status_reen", ST, 8'hff, 8'h91);
    close_out();
  end
endmodule // i2c_slave_status_control_bench
